// [design/rmfi_pkg.sv]
/*
 * Shared constants for the rectifier mode and fault indicator block.
 * Assumes a 50 MHz system clock; sensor comparisons arrive as digital levels.
 */
package rmfi_pkg;
	// Clock rate
	localparam int unsigned CLK_HZ = 50_000_000;
	// Excitation pulse on and off time in ms
	localparam int unsigned EXC_HALF_MS = 500;
	// Over-current blink half period in ms
	localparam int unsigned OC_HALF_MS = 500;
	// Over-temperature blink half period in ms
	localparam int unsigned OT_HALF_MS = 130;
	// Derived cycle counts, rounded down, with no floor at one
	localparam int unsigned EXC_HALF_CYC = CLK_HZ / 1000 * EXC_HALF_MS;
	localparam int unsigned OC_HALF_CYC = CLK_HZ / 1000 * OC_HALF_MS;
	localparam int unsigned OT_HALF_CYC = CLK_HZ / 1000 * OT_HALF_MS;
	// Full-power to low-power delay in ms (arbitrary plain default)
	localparam int unsigned LP_DELAY_MS = 1000;
	localparam int unsigned LP_DELAY_CYC = CLK_HZ / 1000 * LP_DELAY_MS;
	// Counter width for all timers
	localparam int unsigned TMR_W = 32;
	// Indicator count: fault, fuse, array on, low power
	localparam int unsigned LED_N = 4;
	localparam int unsigned LED_FAULT = 0;
	localparam int unsigned LED_FUSE = 1;
	localparam int unsigned LED_ARRAY = 2;
	localparam int unsigned LED_LOWP = 3;
	// Mode states
	typedef enum logic [2:0] {
		RMFI_DIODE,
		RMFI_EXC_ON,
		RMFI_EXC_OFF,
		RMFI_LOWP
	} rmfi_mode_type;
endpackage

// [design/rmfi_top.sv]
/*
 * Mode sequencing and status indication for a power rectifier.
 * Assumes analog comparators deliver level signals from outside the clock
 * domain; indicator outputs drive open-drain stages with external pull-ups.
 */
// How it works
// - Alternator output ends re-excitation, back to diode
// - Keep watching trigger and voltage, restart when needed
// - Trigger off, voltage low, delay done: low power
// - Combine shorted turns array on
// - Each indicator mirrored on open-drain external output
// - Blown fuse lights fuse indicator
// - Over-current above twice rating blinks fault
// - Over-current blink 0.5 s on, 0.5 s off
// - Over-current clears only 10 A below start
// - No over-current flag for reverse current in excitation/combine
// - Above 135 C blinks fault for over-temperature
// - Over-temperature blink 0.13 s on/off
// - Over-temperature clears below 130 C
// - Excitation pulse half second on, half off
// - Re-excitation pulses repeat without count limit
`timescale 1ns/100ps
module rmfi_top
	import rmfi_pkg::*;
#(
	parameter int unsigned EXC_HALF = EXC_HALF_CYC,
	parameter int unsigned OC_HALF  = OC_HALF_CYC,
	parameter int unsigned OT_HALF  = OT_HALF_CYC,
	parameter int unsigned LP_DELAY = LP_DELAY_CYC
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Trigger and sense comparator levels, asynchronous
	input  wire logic             reexcTrigIn,
	input  wire logic             altAboveBatIn,
	input  wire logic             altChargingIn,
	input  wire logic             combineShortIn,
	// Current comparators: above 2x max_continuous_current, above that minus 10 A
	input  wire logic             ocHighIn,
	input  wire logic             ocLowIn,
	input  wire logic             reverseCurrentIn,
	// Temperature comparators: above 135 C, above 130 C
	input  wire logic             otHighIn,
	input  wire logic             otLowIn,
	// Fuse sense, high when blown
	input  wire logic             fuseBlownIn,
	// Power array gate
	output logic                  arrayOn,
	// Low-power state
	output logic                  lowPower,
	// On-board indicators, high lights the lamp
	output logic [LED_N-1:0]      ledOn,
	// External open-drain pins, enable high while pulling low
	output logic [LED_N-1:0]      extLedOut,
	output logic [LED_N-1:0]      extLedOe
);

	localparam int SYNC_N = 10; // Number of synchronised inputs

	// Two-stage synchroniser array
	logic [SYNC_N-1:0] syncA_q;
	logic [SYNC_N-1:0] syncB_q;
	logic [SYNC_N-1:0] rawIn;

	assign rawIn = {fuseBlownIn, otLowIn, otHighIn, reverseCurrentIn, ocLowIn, ocHighIn,
		combineShortIn, altChargingIn, altAboveBatIn, reexcTrigIn};

	// Synchronise every pin before use; first stage feeds only the second
	// Both stages clear on reset, so a pin already high at release
	// still takes two edges to reach the logic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			syncA_q <= rawIn;
			syncB_q <= syncA_q;
		end
	end

	// Named views of synchronised levels
	logic trig, altAbove, altChg, combine, ocHigh, ocLow, revCur, otHigh, otLow, fuse;
	assign trig     = syncB_q[0];
	assign altAbove = syncB_q[1];
	assign altChg   = syncB_q[2];
	assign combine  = syncB_q[3];
	assign ocHigh   = syncB_q[4];
	assign ocLow    = syncB_q[5];
	assign revCur   = syncB_q[6];
	assign otHigh   = syncB_q[7];
	assign otLow    = syncB_q[8];
	assign fuse     = syncB_q[9];

	// Mode state and timers
	rmfi_mode_type     mode_q;
	logic [TMR_W-1:0]  excTmr_q;  // Pulse phase timer
	logic [TMR_W-1:0]  lpTmr_q;   // Low-power entry delay

	// Conditions that call for re-excitation
	logic reexcNeed;
	assign reexcNeed = trig && !altAbove && !altChg;

	// Mode sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q   <= RMFI_DIODE;
			excTmr_q <= '0;
		end else begin
			case (mode_q)
				RMFI_DIODE: begin
					excTmr_q <= '0;
					if (reexcNeed) begin
						mode_q <= RMFI_EXC_ON;
					end else if (!trig && !altAbove && !combine
						&& lpTmr_q >= TMR_W'(LP_DELAY)) begin
						mode_q <= RMFI_LOWP;
					end
				end
				RMFI_EXC_ON: begin
					if (altChg || !trig) begin
						// Charging seen or trigger gone: back to diode
						mode_q   <= RMFI_DIODE;
						excTmr_q <= '0;
					end else if (excTmr_q >= TMR_W'(EXC_HALF - 1)) begin
						mode_q   <= RMFI_EXC_OFF;
						excTmr_q <= '0;
					end else begin
						excTmr_q <= excTmr_q + 1'b1;
					end
				end
				RMFI_EXC_OFF: begin
					// Charging seen or trigger gone during the dark half
					if (altChg || !trig) begin
						mode_q   <= RMFI_DIODE;
						excTmr_q <= '0;
					end else if (excTmr_q >= TMR_W'(EXC_HALF - 1)) begin
						// No pulse count: repeats as long as needed
						mode_q   <= RMFI_EXC_ON;
						excTmr_q <= '0;
					end else begin
						excTmr_q <= excTmr_q + 1'b1;
					end
				end
				RMFI_LOWP: begin
					// Wake on trigger, rising alternator or combine
					excTmr_q <= '0;
					if (trig || altAbove || combine) begin
						mode_q <= RMFI_DIODE;
					end
				end
				default: begin
					mode_q   <= RMFI_DIODE;
					excTmr_q <= '0;
				end
			endcase
		end
	end

	// Low-power delay counts while idle conditions hold, saturating
	// Saturation keeps a long idle spell from wrapping below the delay
	// Any wake source restarts the full delay
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lpTmr_q <= '0;
		end else if (mode_q == RMFI_DIODE && !trig && !altAbove && !combine) begin
			if (lpTmr_q < TMR_W'(LP_DELAY)) begin
				lpTmr_q <= lpTmr_q + 1'b1;
			end
		end else begin
			lpTmr_q <= '0;
		end
	end

	// Array gate: combine overrides, else excitation on-phase or forward diode
	// Low-power mode leaves only combine able to close the array
	// Registered, so the gate never glitches on sensor edges
	logic excMode;
	assign excMode = (mode_q == RMFI_EXC_ON) || (mode_q == RMFI_EXC_OFF);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arrayOn <= 1'b0;
		end else begin
			arrayOn <= combine
				|| (mode_q == RMFI_EXC_ON)
				|| (mode_q == RMFI_DIODE && altAbove);
		end
	end

	// Low-power status flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lowPower <= 1'b0;
		end else begin
			lowPower <= (mode_q == RMFI_LOWP);
		end
	end

	// Over-current flag with hysteresis; reverse current ignored in excitation/combine
	logic ocFlag_q;
	logic ocMasked;
	assign ocMasked = revCur && (excMode || combine);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ocFlag_q <= 1'b0;
		end else if (ocMasked) begin
			ocFlag_q <= 1'b0;
		end else if (ocHigh) begin
			ocFlag_q <= 1'b1;
		end else if (!ocLow) begin
			ocFlag_q <= 1'b0;
		end
	end

	// Over-temperature flag with hysteresis
	logic otFlag_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			otFlag_q <= 1'b0;
		end else if (otHigh) begin
			otFlag_q <= 1'b1;
		end else if (!otLow) begin
			otFlag_q <= 1'b0;
		end
	end

	// Blink tick counters: own phase per pattern, running only while its flag is set
	// One counter per pattern, so a priority swap never restarts the other
	logic [TMR_W-1:0] ocTmr_q;
	logic [TMR_W-1:0] otTmr_q;
	logic             ocPhase_q;
	logic             otPhase_q;

	// Over-current blink timer; restarts lit when flag is idle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ocTmr_q   <= '0;
			ocPhase_q <= 1'b1;
		end else if (!ocFlag_q) begin
			ocTmr_q   <= '0;
			ocPhase_q <= 1'b1;
		end else if (ocTmr_q >= TMR_W'(OC_HALF - 1)) begin
			ocTmr_q   <= '0;
			ocPhase_q <= !ocPhase_q;
		end else begin
			ocTmr_q <= ocTmr_q + 1'b1;
		end
	end

	// Over-temperature blink timer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			otTmr_q   <= '0;
			otPhase_q <= 1'b1;
		end else if (!otFlag_q) begin
			otTmr_q   <= '0;
			otPhase_q <= 1'b1;
		end else if (otTmr_q >= TMR_W'(OT_HALF - 1)) begin
			otTmr_q   <= '0;
			otPhase_q <= !otPhase_q;
		end else begin
			otTmr_q <= otTmr_q + 1'b1;
		end
	end

	// Indicator levels before output flops
	// Array lamp reads the registered gate, so it trails it by one edge
	// Low-power lamp reads the mode directly to line up with lowPower
	logic [LED_N-1:0] ledD;
	always_comb begin
		ledD = '0;
		// Temperature pattern wins the shared lamp
		if (otFlag_q) begin
			ledD[LED_FAULT] = otPhase_q;
		end else if (ocFlag_q) begin
			ledD[LED_FAULT] = ocPhase_q;
		end
		ledD[LED_FUSE]  = fuse;
		ledD[LED_ARRAY] = arrayOn;
		ledD[LED_LOWP]  = (mode_q == RMFI_LOWP);
	end

	// Per-indicator output flops, on-board and external mirror
	genvar gi;
	generate
		for (gi = 0; gi < LED_N; gi++) begin : g_led
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					ledOn[gi]     <= 1'b0;
					extLedOut[gi] <= 1'b0;
					extLedOe[gi]  <= 1'b0;
				end else begin
					ledOn[gi]     <= ledD[gi];
					// Open drain: drive low only when lit
					// Data stays low; only the enable moves, never driving high
					extLedOut[gi] <= 1'b0;
					extLedOe[gi]  <= ledD[gi];
				end
			end
		end
	endgenerate

endmodule

// [verification/rmfi_checker.sv]
/* Timing checks on the rectifier mode and lamp ports.
   Bound into rmfi_top; sees only its ports, one clock domain. */
`timescale 1ns/100ps
module rmfi_checker
	import rmfi_pkg::*;
#(
	parameter int unsigned OT_HALF  = OT_HALF_CYC,
	parameter int unsigned LP_DELAY = LP_DELAY_CYC
) (
	// Clock and reset
	input wire logic             sys_clk,
	input wire logic             rst_n,
	// Sensor levels as they stand on the pins
	input wire logic             reexcTrigIn,
	input wire logic             altAboveBatIn,
	input wire logic             altChargingIn,
	input wire logic             combineShortIn,
	input wire logic             ocHighIn,
	input wire logic             ocLowIn,
	input wire logic             reverseCurrentIn,
	input wire logic             otHighIn,
	input wire logic             otLowIn,
	input wire logic             fuseBlownIn,
	// Array, mode and lamps
	input wire logic             arrayOn,
	input wire logic             lowPower,
	input wire logic [LED_N-1:0] ledOn,
	input wire logic [LED_N-1:0] extLedOut,
	input wire logic [LED_N-1:0] extLedOe
);
	logic prevF_q; // Fault lamp one sample ago
	int   runF_q;  // Length of current fault lamp run
	int   otRun_q; // Samples of over-temperature since a high trip
	int   quiet_q; // Samples with no wake source
	// Run counters; raw inputs, so sync lag is allowed for in each property
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevF_q <= 1'b0;
			runF_q <= 0;
			otRun_q <= 0;
			quiet_q <= 0;
		end else begin
			prevF_q <= ledOn[LED_FAULT];
			runF_q <= (ledOn[LED_FAULT] != prevF_q) ? 1 : runF_q + 1;
			otRun_q <= (otLowIn && (otHighIn || otRun_q > 0)) ? otRun_q + 1 : 0;
			quiet_q <= (reexcTrigIn || altAboveBatIn || combineShortIn) ? 0 : quiet_q + 1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_comb; combineShortIn [*5] |-> arrayOn; endproperty
	a_comb: assert property (p_comb) else $error("array off while combined");
	property p_mirror; extLedOe == ledOn; endproperty
	a_mirror: assert property (p_mirror) else $error("pin differs from lamp");
	property p_od; extLedOut == '0; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_fuse; $stable(fuseBlownIn) [*5] |-> ledOn[LED_FUSE] == fuseBlownIn; endproperty
	a_fuse: assert property (p_fuse) else $error("fuse lamp wrong");
	// Fault lamp toggles only after a full hot half period
	property p_ot; otRun_q > 10 && ledOn[LED_FAULT] != prevF_q |-> runF_q == OT_HALF; endproperty
	a_ot: assert property (p_ot) else $error("hot blink period wrong");
	property p_clr; (!otLowIn && !ocLowIn) [*6] |-> !ledOn[LED_FAULT]; endproperty
	a_clr: assert property (p_clr) else $error("fault lamp stuck");
	property p_lowp; $rose(lowPower) |-> quiet_q >= LP_DELAY; endproperty
	a_lowp: assert property (p_lowp) else $error("low power too early");
	property p_wake; (reexcTrigIn || altAboveBatIn || combineShortIn) [*5] |-> !lowPower; endproperty
	a_wake: assert property (p_wake) else $error("low power while awake");
	property p_exit; (altChargingIn && !altAboveBatIn && !combineShortIn) [*6] |-> !arrayOn;
	endproperty
	a_exit: assert property (p_exit) else $error("pulsing while charging");
endmodule

bind rmfi_top rmfi_checker #(.OT_HALF(OT_HALF), .LP_DELAY(LP_DELAY)) u_chk (.*);

// [verification/rmfi_lamps.sv]
/* Far-side lamps and pull-ups of the status harness.
   Each pin rests high through its pull-up unless the block sinks it. */
`timescale 1ns/100ps
module rmfi_lamps
	import rmfi_pkg::*;
(
	// Open-drain drive from the block
	input  wire logic [LED_N-1:0] extLedOut,
	input  wire logic [LED_N-1:0] extLedOe,
	// Pin levels, low means lamp lit
	output logic      [LED_N-1:0] pinLvl
);
	// Pull-up wins wherever the block lets go
	always_comb begin
		for (int i = 0; i < LED_N; i++)
			pinLvl[i] = extLedOe[i] ? extLedOut[i] : 1'b1;
	end
endmodule

// [verification/rmfi_test.sv]
/* Self-checking bench for rmfi_top with short timer parameters.
   Sensor levels change at falling edges; lamp pins come from rmfi_lamps. */
`timescale 1ns/100ps
module rmfi_test;
	import rmfi_pkg::*;
	localparam int EH = 4, OCH = 4, OTH = 2, LPD = 8; // Shortened timers
	logic sys_clk, rst_n, trig, altAb, altChg, comb, ocH, ocL, rev, otH, otL, fuse;
	logic arrayOn, lowPower;
	logic [LED_N-1:0] ledOn, extLedOut, extLedOe, pinLvl;
	int num_errors, compares;
	rmfi_top #(.EXC_HALF(EH), .OC_HALF(OCH), .OT_HALF(OTH), .LP_DELAY(LPD)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reexcTrigIn(trig), .altAboveBatIn(altAb),
		.altChargingIn(altChg), .combineShortIn(comb), .ocHighIn(ocH), .ocLowIn(ocL),
		.reverseCurrentIn(rev), .otHighIn(otH), .otLowIn(otL), .fuseBlownIn(fuse),
		.arrayOn(arrayOn), .lowPower(lowPower), .ledOn(ledOn), .extLedOut(extLedOut),
		.extLedOe(extLedOe));
	rmfi_lamps u_lamps (.extLedOut(extLedOut), .extLedOe(extLedOe), .pinLvl(pinLvl));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic sig(bit sel);
		return sel ? arrayOn : ledOn[LED_FAULT];
	endfunction
	// Count samples at one level; a stuck output ends the run
	task automatic run(bit sel, logic lvl, output int n);
		n = 0;
		while (sig(sel) === lvl) begin
			cyc(1);
			n++;
			if (n > 300) begin
				num_errors++;
				end_sim();
			end
		end
	endtask
	// Time one full lit and dark phase, skipping a partial first one
	task automatic blink(bit sel, int half);
		int n;
		run(sel, 1'b1, n);
		run(sel, 1'b0, n);
		run(sel, 1'b1, n);
		chk("lit cycles", half, n);
		run(sel, 1'b0, n);
		chk("dark cycles", half, n);
	endtask
	task automatic sc_combine;
		comb = 1'b1;
		cyc(6);
		chk("array", 1, arrayOn);
		chk("pins", 4'hb, pinLvl);
		comb = 1'b0;
		cyc(6);
		chk("pins", 4'hf, pinLvl);
	endtask
	task automatic sc_current;
		{comb, rev, ocH, ocL} = 4'hf;
		cyc(12);
		chk("fault", 0, ledOn[LED_FAULT]);
		rev = 1'b0;
		blink(0, OCH);
		comb = 1'b0;
		ocH = 1'b0;
		blink(0, OCH);
		ocL = 1'b0;
		cyc(8);
		chk("fault", 0, ledOn[LED_FAULT]);
	endtask
	task automatic sc_temp;
		{ocH, ocL, otH, otL} = 4'hf;
		blink(0, OTH);
		otH = 1'b0;
		blink(0, OTH);
		otL = 1'b0;
		// Let the cleared hot flag hand the lamp back before timing
		cyc(8);
		blink(0, OCH);
		{ocH, ocL, fuse} = 3'h1;
		cyc(8);
		chk("lamps", 4'h2, ledOn);
		fuse = 1'b0;
	endtask
	task automatic sc_excite;
		altChg = 1'b0;
		blink(1, EH);
		blink(1, EH);
		altChg = 1'b1;
		cyc(30);
		chk("array", 0, arrayOn);
		altChg = 1'b0;
		blink(1, EH);
		altChg = 1'b1;
	endtask
	task automatic sc_lowp;
		{trig, altAb} = 2'h1;
		cyc(LPD + 8);
		chk("array", 1, arrayOn);
		chk("low", 0, lowPower);
		altAb = 1'b0;
		cyc(LPD);
		chk("low", 0, lowPower);
		cyc(8);
		chk("lamps", 4'h8, ledOn);
		trig = 1'b1;
		cyc(6);
		chk("low", 0, lowPower);
	endtask
	// Mid-run reset: outputs clear at once and stay clear two edges after release
	task automatic sc_reset;
		{comb, fuse} = 2'h3;
		cyc(6);
		chk("lamps", 4'h6, ledOn);
		rst_n = 1'b0;
		cyc(2);
		chk("array", 0, arrayOn);
		chk("lamps", 0, ledOn);
		chk("pins", 4'hf, pinLvl);
		rst_n = 1'b1;
		cyc(2);
		chk("array", 0, arrayOn);
		chk("lamps", 0, ledOn);
		cyc(4);
		chk("array", 1, arrayOn);
		chk("lamps", 4'h6, ledOn);
		{comb, fuse} = 2'h0;
	endtask
	initial begin
		{altAb, comb, ocH, ocL, rev, otH, otL, fuse} = '0;
		{trig, altChg} = 2'h3;
		rst_n = 1'b0;
		num_errors = 0;
		compares = 0;
		cyc(2);
		rst_n = 1'b1;
		sc_combine();
		sc_current();
		sc_temp();
		sc_excite();
		sc_lowp();
		sc_reset();
		end_sim();
	end
endmodule
